//--- rtl/laser_regs_pkg.sv
package laser_regs_pkg;

  // ------------------------------------------------------------
  // Register addresses on the serial port
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_MOTION = 7'h02;
  localparam logic [6:0] ADDR_FW_ENABLE = 7'h13;
  localparam logic [6:0] ADDR_LASER_CTRL = 7'h20;
  localparam logic [6:0] ADDR_OBSERVATION = 7'h24;
  localparam logic [6:0] ADDR_CRC_LOW = 7'h25;
  localparam logic [6:0] ADDR_CRC_HIGH = 7'h26;
  localparam logic [6:0] ADDR_FW_REVISION = 7'h2a;
  localparam logic [6:0] ADDR_LIFT_THR = 7'h2e;
  localparam logic [6:0] ADDR_Y_RES = 7'h2f;

  // ------------------------------------------------------------
  // Field positions, codes and reset values
  // ------------------------------------------------------------
  localparam int FORCE_BIT = 0;
  localparam int CW_LSB = 1;
  localparam int CW_MSB = 3;
  localparam int OBS_FRAME_MSB = 5;
  localparam int OBS_FW_BIT = 6;
  localparam int LIFT_MSB = 4;
  localparam logic [2:0] CW_ON = 3'b010;
  localparam logic [2:0] CW_OFF = 3'b000;
  localparam logic [7:0] FW_CRC_CMD = 8'h15;
  localparam logic [7:0] LASER_CTRL_RESET = 8'h81;
  localparam logic [5:0] OBS_RESET = 6'h00;
  localparam logic [4:0] LIFT_RESET = 5'h10;
  localparam logic [7:0] Y_RES_RESET = 8'h01;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  localparam logic [15:0] CPI_PER_STEP = 16'h005a;

  // ------------------------------------------------------------
  // Serial port framing
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam logic [3:0] DATA_FIRST_BIT = 4'h8;
  localparam logic [3:0] DATA_LAST_BIT = 4'hf;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } serial_req_t;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic o_level
);

  logic meta_r;
  logic meta_nxt;
  logic level_r;
  logic level_nxt;

  always_comb
  begin
    meta_nxt = i_pin;
    level_nxt = meta_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      meta_r <= RESET_VAL;
      level_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;

endmodule

`default_nettype wire

//--- rtl/serial_shifter.sv
`timescale 1ns/1ns
`default_nettype none

module serial_shifter (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_ncs,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output laser_regs_pkg::serial_req_t o_req,
  output logic o_miso,
  output logic o_miso_oe
);
  import laser_regs_pkg::*;

  logic sclk_d_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [6:0] shift_in_r;
  logic [6:0] shift_in_nxt;
  logic [6:0] addr_r;
  logic [6:0] addr_nxt;
  logic is_write_r;
  logic is_write_nxt;
  logic [7:0] shift_out_r;
  logic [7:0] shift_out_nxt;
  logic miso_r;
  logic miso_nxt;
  logic oe_r;
  serial_req_t req_r;
  serial_req_t req_nxt;
  logic rise;
  logic fall;

  // ------------------------------------------------------------
  // Frame decode: address byte, then data byte, MSB first
  // ------------------------------------------------------------
  always_comb
  begin
    rise = i_sclk & ~sclk_d_r;
    fall = ~i_sclk & sclk_d_r;
    cnt_nxt = cnt_r;
    shift_in_nxt = shift_in_r;
    addr_nxt = addr_r;
    is_write_nxt = is_write_r;
    shift_out_nxt = shift_out_r;
    miso_nxt = miso_r;
    req_nxt = '0;
    if (i_ncs)
    begin
      cnt_nxt = 4'h0;
    end
    else
    begin
      if (rise)
      begin
        shift_in_nxt = {shift_in_r[5:0], i_mosi};
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == ADDR_LAST_BIT)
        begin
          addr_nxt = {shift_in_r[5:0], i_mosi};
          is_write_nxt = shift_in_r[6];
          req_nxt.rd = ~shift_in_r[6];
          req_nxt.addr = {shift_in_r[5:0], i_mosi};
        end
        if (cnt_r == DATA_LAST_BIT)
        begin
          req_nxt.wr = is_write_r;
          req_nxt.addr = addr_r;
          req_nxt.data = {shift_in_r, i_mosi};
        end
      end
      if (fall && (cnt_r >= DATA_FIRST_BIT))
      begin
        miso_nxt = shift_out_r[7];
        shift_out_nxt = {shift_out_r[6:0], 1'b0};
      end
    end
    if (i_rd_valid)
    begin
      shift_out_nxt = i_rd_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sclk_d_r <= 1'b1;
      cnt_r <= 4'h0;
      shift_in_r <= 7'h00;
      addr_r <= 7'h00;
      is_write_r <= 1'b0;
      shift_out_r <= 8'h00;
      miso_r <= 1'b0;
      oe_r <= 1'b0;
      req_r <= '0;
    end
    else
    begin
      sclk_d_r <= i_sclk;
      cnt_r <= cnt_nxt;
      shift_in_r <= shift_in_nxt;
      addr_r <= addr_nxt;
      is_write_r <= is_write_nxt;
      shift_out_r <= shift_out_nxt;
      miso_r <= miso_nxt;
      oe_r <= ~i_ncs;
      req_r <= req_nxt;
    end
  end

  assign o_req = req_r;
  assign o_miso = miso_r;
  assign o_miso_oe = oe_r;

endmodule

`default_nettype wire

//--- rtl/laser_sensor_config_status_regs.sv
// What this block does
// - Writing 010 into drive mode bits 3..1 turns continuous-on laser mode on.
// - Writing 000 leaves continuous-on mode; other codes are for software to avoid.
// - Reading the motion register clears drive mode to 000, ending continuous-on.
// - Bit 0 of laser control forces the active-low laser enable to disabled.
// - Active processes set their observation bits 5..0 once each frame.
// - Observation bit 6 reads 1 while running downloaded firmware.
// - Two read-only registers hold the 16-bit firmware CRC result.
// - Writing 0x15 to firmware enable starts the CRC test.
// - Firmware revision reads the revision only when loaded and running, else 0.
// - Lift threshold is five bits, resets to 0x10, higher means higher lift.
// - Y resolution applies only when independent axis reporting is on.
// - Y resolution in cpi is the register value times 90.
`timescale 1ns/1ns
`default_nettype none

module laser_sensor_config_status_regs (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_ncs,
  input wire logic i_frame_tick,
  input wire logic [5:0] i_proc_active,
  input wire logic i_fw_running,
  input wire logic i_fw_download_ok,
  input wire logic [7:0] i_fw_revision,
  input wire logic i_crc_done,
  input wire logic [15:0] i_crc_value,
  input wire logic i_laser_pulse,
  input wire logic i_independent_axis,
  input wire logic [15:0] i_common_y_cpi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_crc_start,
  output logic o_laser_drive_enable_low,
  output logic o_continuous_on,
  output logic [4:0] o_lift_threshold_field,
  output logic [15:0] o_y_cpi
);
  import laser_regs_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers and serial port
  // ------------------------------------------------------------
  logic sclk_s;
  logic mosi_s;
  logic ncs_s;
  serial_req_t req;

  pin_sync #(.RESET_VAL(1'b1)) u_sync_sclk (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_sclk),
    .o_level(sclk_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_mosi (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_mosi),
    .o_level(mosi_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_ncs (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_ncs),
    .o_level(ncs_s)
  );

  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  serial_shifter u_shifter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sclk(sclk_s),
    .i_mosi(mosi_s),
    .i_ncs(ncs_s),
    .i_rd_valid(rd_valid_r),
    .i_rd_data(rd_data_r),
    .o_req(req),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe)
  );

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [2:0] cw_r;
  logic [2:0] cw_nxt;
  logic force_r;
  logic force_nxt;
  logic [3:0] rsvd_r;
  logic [3:0] rsvd_nxt;
  logic [5:0] obs_r;
  logic [5:0] obs_nxt;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [4:0] lift_r;
  logic [4:0] lift_nxt;
  logic [7:0] yres_r;
  logic [7:0] yres_nxt;
  logic crc_start_r;
  logic crc_start_nxt;
  logic laser_en_low_r;
  logic laser_en_low_nxt;
  logic cont_on_r;
  logic cont_on_nxt;
  logic [15:0] y_cpi_r;
  logic [15:0] y_cpi_nxt;
  logic wr_hit;

  always_comb
  begin
    cw_nxt = cw_r;
    force_nxt = force_r;
    rsvd_nxt = rsvd_r;
    lift_nxt = lift_r;
    yres_nxt = yres_r;
    crc_nxt = crc_r;
    crc_start_nxt = 1'b0;
    wr_hit = req.wr && (req.addr == ADDR_OBSERVATION);
    // Write stores value; a frame's set wins over a same-cycle clear
    obs_nxt = wr_hit ? req.data[OBS_FRAME_MSB:0] : obs_r;
    if (i_frame_tick)
    begin
      obs_nxt = obs_nxt | i_proc_active;
    end
    if (req.wr)
    begin
      unique case (req.addr)
        ADDR_LASER_CTRL:
        begin
          cw_nxt = req.data[CW_MSB:CW_LSB];
          force_nxt = req.data[FORCE_BIT];
          // Reserved bits keep their reset pattern until written
          rsvd_nxt = req.data[7:CW_MSB + 1];
        end
        ADDR_FW_ENABLE:
        begin
          crc_start_nxt = (req.data == FW_CRC_CMD);
        end
        ADDR_LIFT_THR:
        begin
          lift_nxt = req.data[LIFT_MSB:0];
        end
        ADDR_Y_RES:
        begin
          yres_nxt = req.data;
        end
        default:
        begin
          cw_nxt = cw_r;
        end
      endcase
    end
    if (req.rd && (req.addr == ADDR_MOTION))
    begin
      cw_nxt = CW_OFF;
    end
    if (i_crc_done)
    begin
      crc_nxt = i_crc_value;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb
  begin
    rd_valid_nxt = req.rd;
    rd_data_nxt = rd_data_r;
    if (req.rd)
    begin
      // Unused bits read as zero; laser reserved bits echo their stored value
      unique case (req.addr)
        ADDR_LASER_CTRL: rd_data_nxt = {rsvd_r, cw_r, force_r};
        ADDR_OBSERVATION: rd_data_nxt = {1'b0, i_fw_running, obs_r};
        ADDR_CRC_LOW: rd_data_nxt = crc_r[7:0];
        ADDR_CRC_HIGH: rd_data_nxt = crc_r[15:8];
        ADDR_FW_REVISION: rd_data_nxt = (i_fw_download_ok && i_fw_running) ? i_fw_revision : 8'h00;
        ADDR_LIFT_THR: rd_data_nxt = {3'h0, lift_r};
        ADDR_Y_RES: rd_data_nxt = yres_r;
        default: rd_data_nxt = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Laser outputs
  // ------------------------------------------------------------
  always_comb
  begin
    cont_on_nxt = (cw_r == CW_ON);
    laser_en_low_nxt = force_r ? 1'b1 : ~(i_laser_pulse | cont_on_nxt);
  end

  // ------------------------------------------------------------
  // Resolution output
  // ------------------------------------------------------------
  always_comb
  begin
    y_cpi_nxt = i_common_y_cpi;
    if (i_independent_axis)
    begin
      y_cpi_nxt = 16'(16'(yres_r) * CPI_PER_STEP);
    end
  end

  // ------------------------------------------------------------
  // Laser control registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rsvd_r <= LASER_CTRL_RESET[7:CW_MSB + 1];
      cw_r <= LASER_CTRL_RESET[CW_MSB:CW_LSB];
      force_r <= LASER_CTRL_RESET[FORCE_BIT];
      laser_en_low_r <= 1'b1;
      cont_on_r <= 1'b0;
    end
    else
    begin
      rsvd_r <= rsvd_nxt;
      cw_r <= cw_nxt;
      force_r <= force_nxt;
      laser_en_low_r <= laser_en_low_nxt;
      cont_on_r <= cont_on_nxt;
    end
  end

  // ------------------------------------------------------------
  // Observation and CRC registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      obs_r <= OBS_RESET;
      crc_r <= CRC_RESET;
      crc_start_r <= 1'b0;
    end
    else
    begin
      obs_r <= obs_nxt;
      crc_r <= crc_nxt;
      crc_start_r <= crc_start_nxt;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      lift_r <= LIFT_RESET;
      yres_r <= Y_RES_RESET;
      y_cpi_r <= 16'h0000;
    end
    else
    begin
      lift_r <= lift_nxt;
      yres_r <= yres_nxt;
      y_cpi_r <= y_cpi_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end
    else
    begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign o_crc_start = crc_start_r;
  assign o_laser_drive_enable_low = laser_en_low_r;
  assign o_continuous_on = cont_on_r;
  assign o_lift_threshold_field = lift_r;
  assign o_y_cpi = y_cpi_r;

endmodule

`default_nettype wire

//--- bench/serial_host.sv
`timescale 1ns/1ns
`default_nettype none

module serial_host (
  input wire logic i_clk,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_ncs
);
  initial
  begin
    o_sclk = 1'b1;
    o_mosi = 1'b0;
    o_ncs = 1'b1;
  end

  // ----------------------------------------
  // One 16-clock access, MSB first
  // ----------------------------------------
  task automatic xfer(input logic [15:0] w, output logic [7:0] q);
    o_ncs = 1'b0;
    repeat (6) @(negedge i_clk);
    for (int i = 15; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      o_mosi = w[i];
      repeat (6) @(negedge i_clk);
      q = {q[6:0], i_miso};
      o_sclk = 1'b1;
      repeat (6) @(negedge i_clk);
    end
    o_ncs = 1'b1;
    o_mosi = ~o_mosi;
    repeat (6) @(negedge i_clk);
  endtask
endmodule

`default_nettype wire

//--- bench/laser_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none

module laser_regs_chk
  import laser_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ncs,
  input wire logic i_laser_pulse,
  input wire logic i_independent_axis,
  input wire logic [15:0] i_common_y_cpi,
  input wire logic o_miso_oe,
  input wire logic o_crc_start,
  input wire logic o_laser_drive_enable_low,
  input wire logic o_continuous_on,
  input wire logic [4:0] o_lift_threshold_field,
  input wire logic [15:0] o_y_cpi
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_ncs_high;
    i_ncs [*5];
  endsequence
  sequence s_ncs_low;
    !i_ncs [*5];
  endsequence

  a_reset_values: assert property ($fell(i_srst) |-> o_lift_threshold_field == LIFT_RESET &&
    !o_continuous_on && o_laser_drive_enable_low && !o_crc_start && !o_miso_oe)
    else $error("reset values wrong");
  a_crc_one_cycle: assert property (o_crc_start |=> !o_crc_start)
    else $error("crc start longer than one cycle");
  a_laser_enable_cause: assert property (!o_laser_drive_enable_low |->
    $past(i_laser_pulse) || $past(o_continuous_on) || o_continuous_on)
    else $error("laser enabled without cause");
  a_cw_end_cause: assert property ($fell(o_continuous_on) |-> $past(!i_ncs) || $past(i_srst))
    else $error("continuous mode ended without access");
  a_y_common: assert property ($past(!i_independent_axis) && $past(!i_srst) |->
    o_y_cpi == $past(i_common_y_cpi))
    else $error("y cpi not common value");
  a_y_scaled: assert property ($past(i_independent_axis) && $past(!i_srst) |->
    o_y_cpi % 16'd90 == 16'd0 && o_y_cpi != 16'd0)
    else $error("y cpi not a step multiple");
  a_lift_by_access: assert property ($changed(o_lift_threshold_field) && $past(!i_srst) |->
    $past(!i_ncs))
    else $error("lift threshold changed without access");
  a_oe_idle: assert property (s_ncs_high |-> !o_miso_oe)
    else $error("miso driven while deselected");
  a_oe_active: assert property (s_ncs_low |-> o_miso_oe)
    else $error("miso not driven while selected");
endmodule

bind laser_sensor_config_status_regs laser_regs_chk u_chk (
  .i_clk(i_clk),
  .i_srst(i_srst),
  .i_ncs(i_ncs),
  .i_laser_pulse(i_laser_pulse),
  .i_independent_axis(i_independent_axis),
  .i_common_y_cpi(i_common_y_cpi),
  .o_miso_oe(o_miso_oe),
  .o_crc_start(o_crc_start),
  .o_laser_drive_enable_low(o_laser_drive_enable_low),
  .o_continuous_on(o_continuous_on),
  .o_lift_threshold_field(o_lift_threshold_field),
  .o_y_cpi(o_y_cpi)
);

`default_nettype wire

//--- bench/laser_sensor_config_status_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

module laser_sensor_config_status_regs_tb;
  import laser_regs_pkg::*;
  logic i_clk = 1'b0, i_srst = 1'b1, sclk, mosi, ncs, tick = 1'b0, fw_run = 1'b0, fw_ok = 1'b0;
  logic crc_done = 1'b0, pulse = 1'b0, indep = 1'b0;
  logic [5:0] proc = 6'h00;
  logic [7:0] rev = 8'h5c;
  logic [15:0] crc_val = 16'h0000, common = 16'h0640;
  logic miso, oe, crc_start, en_low, cw;
  logic [4:0] lift;
  logic [15:0] y_cpi;
  int mismatches = 0, samples_checked = 0, crc_seen = 0;

  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (crc_start === 1'b1) crc_seen++;

  serial_host host (.i_clk(i_clk), .i_miso(miso), .o_sclk(sclk), .o_mosi(mosi), .o_ncs(ncs));
  laser_sensor_config_status_regs dut (.i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_mosi(mosi),
    .i_ncs(ncs), .i_frame_tick(tick), .i_proc_active(proc), .i_fw_running(fw_run),
    .i_fw_download_ok(fw_ok), .i_fw_revision(rev), .i_crc_done(crc_done), .i_crc_value(crc_val),
    .i_laser_pulse(pulse), .i_independent_axis(indep), .i_common_y_cpi(common), .o_miso(miso),
    .o_miso_oe(oe), .o_crc_start(crc_start), .o_laser_drive_enable_low(en_low),
    .o_continuous_on(cw), .o_lift_threshold_field(lift), .o_y_cpi(y_cpi));

  // ----------------------------------------
  // Shared access and compare tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer({1'b1, a, d}, q);
  endtask
  task automatic rc(input string n, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer({1'b0, a, 8'h00}, q);
    chk(n, {8'h00, e}, {8'h00, q});
  endtask
  task automatic do_reset();
    i_srst = 1'b1;
    repeat (4) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rc("laser_ctrl", ADDR_LASER_CTRL, 8'h81);
    chk("enable_low", 16'h0001, {15'h0000, en_low});
    rc("obs", ADDR_OBSERVATION, 8'h00);
    rc("lift", ADDR_LIFT_THR, 8'h10);
    rc("unmapped", 7'h7e, 8'h00);
  endtask
  task automatic t_laser();
    wr(ADDR_LASER_CTRL, 8'h04);
    chk("cw_on", 16'h0001, {15'h0000, cw});
    chk("en_cw", 16'h0000, {15'h0000, en_low});
    rc("motion", ADDR_MOTION, 8'h00);
    chk("cw_motion", 16'h0000, {15'h0000, cw});
    rc("cw_field", ADDR_LASER_CTRL, 8'h00);
    wr(ADDR_LASER_CTRL, 8'h04);
    wr(ADDR_LASER_CTRL, 8'h00);
    chk("cw_off", 16'h0000, {15'h0000, cw});
    pulse = 1'b1;
    wr(ADDR_LASER_CTRL, 8'h01);
    chk("en_force", 16'h0001, {15'h0000, en_low});
    wr(ADDR_LASER_CTRL, 8'h00);
    chk("en_norm", 16'h0000, {15'h0000, en_low});
    pulse = 1'b0;
  endtask
  task automatic t_obs();
    wr(ADDR_OBSERVATION, 8'h00);
    proc = 6'h2a;
    fw_run = 1'b1;
    tick = 1'b1;
    @(negedge i_clk);
    tick = 1'b0;
    rc("obs_frame", ADDR_OBSERVATION, 8'h6a);
    fw_run = 1'b0;
    wr(ADDR_OBSERVATION, 8'h00);
    rc("obs_clear", ADDR_OBSERVATION, 8'h00);
  endtask
  task automatic t_crc();
    wr(ADDR_FW_ENABLE, 8'h14);
    chk("no_start", 16'h0000, crc_seen[15:0]);
    wr(ADDR_FW_ENABLE, FW_CRC_CMD);
    chk("start", 16'h0001, crc_seen[15:0]);
    crc_val = 16'hbeef;
    crc_done = 1'b1;
    @(negedge i_clk);
    crc_done = 1'b0;
    wr(ADDR_CRC_LOW, 8'h00);
    rc("crc_hi", ADDR_CRC_HIGH, 8'hbe);
    rc("crc_lo", ADDR_CRC_LOW, 8'hef);
    rc("crc_hi2", ADDR_CRC_HIGH, 8'hbe);
  endtask
  task automatic t_rev();
    fw_ok = 1'b1;
    rc("rev_idle", ADDR_FW_REVISION, 8'h00);
    fw_run = 1'b1;
    rc("rev_run", ADDR_FW_REVISION, 8'h5c);
    fw_ok = 1'b0;
    rc("rev_bad", ADDR_FW_REVISION, 8'h00);
    fw_run = 1'b0;
  endtask
  task automatic t_cfg();
    wr(ADDR_LIFT_THR, 8'h1f);
    chk("lift_out", 16'h001f, {11'h000, lift});
    rc("lift_rd", ADDR_LIFT_THR, 8'h1f);
    indep = 1'b1;
    wr(ADDR_Y_RES, 8'h37);
    chk("y_max", 16'h1356, y_cpi);
    rc("y_rd", ADDR_Y_RES, 8'h37);
    indep = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("y_common", 16'h0640, y_cpi);
  endtask

  initial
  begin
    repeat (30000) @(posedge i_clk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    do_reset();
    t_reset();
    t_laser();
    t_obs();
    t_crc();
    t_rev();
    t_cfg();
    do_reset();
    t_reset();
    print_verdict();
  end
endmodule

`default_nettype wire
